// file: src/gpt16_timer.v
// gated prescaled 16-bit timer/counter with register port
//
// The implementer's own choices: the strobed register port and the register addresses.
`default_nettype none
`include "gpt16_regs.vh"

module gpt16_timer #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             i_ref_clk,
    input  wire             i_reset_n,
    // register port
    input  wire [3:0]       i_addr,
    input  wire [15:0]      i_wdata,
    input  wire             i_wr,
    input  wire             i_rd,
    output reg  [15:0]      o_rdata,
    // power modes
    input  wire             i_idle,
    input  wire             i_sleep,
    // external pins
    input  wire             i_ext_count_input,
    input  wire             i_gate,
    // event outputs
    output reg              o_irq_flag,
    output reg              o_match_pulse
);

////////////////////////////////////////////////////////////////////////////////
// registers

reg  [15:0]      control_q;
reg  [WIDTH-1:0] period_q;
reg  [WIDTH-1:0] count_q;
reg  [WIDTH-1:0] count_d;
reg  [7:0]       psc_q;
reg  [7:0]       psc_d;
reg              half_q;
reg              ext_s1_q;
reg              ext_s2_q;
reg              ext_prev_q;
reg              gate_prev_q;
reg              flag_q;
reg              flag_d;
reg  [15:0]      rdata_d;

wire timer_on  = control_q[`GPT16_BIT_TIMER_ON];
wire idle_stop = control_q[`GPT16_BIT_IDLE_STOP];
wire gate_en   = control_q[`GPT16_BIT_GATE_EN];
wire ext_sync  = control_q[`GPT16_BIT_EXT_SYNC];
wire clk_src   = control_q[`GPT16_BIT_CLK_SRC];
wire [1:0] psc_sel = control_q[`GPT16_BIT_PSC_HI:`GPT16_BIT_PSC_LO];

////////////////////////////////////////////////////////////////////////////////
// register decode

wire wr_control = i_wr & (i_addr == `GPT16_ADDR_CONTROL);
wire wr_period  = i_wr & (i_addr == `GPT16_ADDR_PERIOD);
wire wr_count   = i_wr & (i_addr == `GPT16_ADDR_COUNT);
wire wr_status  = i_wr & (i_addr == `GPT16_ADDR_STATUS);
wire clr_flag   = wr_status & i_wdata[`GPT16_BIT_FLAG];

////////////////////////////////////////////////////////////////////////////////
// time base selection

// external input either through two stages or taken straight
wire ext_level = ext_sync ? ext_s2_q : i_ext_count_input;
wire ext_rise  = ext_level & ~ext_prev_q;
wire gate_fall = gate_prev_q & ~i_gate;

reg  [7:0] psc_term;
always @* begin
    case (psc_sel)
        2'b11:   psc_term = `GPT16_PSC_DIV256;
        2'b10:   psc_term = `GPT16_PSC_DIV64;
        2'b01:   psc_term = `GPT16_PSC_DIV8;
        default: psc_term = `GPT16_PSC_DIV1;
    endcase
end

// sleep stops the internal clock; external pin keeps counting
wire run       = timer_on & ~(i_idle & idle_stop);
wire int_tick  = half_q & ~i_sleep;
wire gated     = gate_en & ~clk_src;
wire src_tick  = clk_src ? ext_rise : (int_tick & (~gated | i_gate));
wire psc_done  = (psc_q == psc_term);
wire cnt_tick  = run & src_tick & psc_done;
wire at_period = (count_q == period_q);
wire match_evt = cnt_tick & at_period;
wire gate_evt  = gated & run & gate_fall;

////////////////////////////////////////////////////////////////////////////////
// next values

// control write restarts the prescaler so a new ratio starts clean
always @* begin
    psc_d = psc_q;
    if (wr_control) begin
        psc_d = 8'h00;
    end else if (run && src_tick) begin
        psc_d = psc_done ? 8'h00 : psc_q + 8'h01;
    end
end

always @* begin
    count_d = count_q;
    if (wr_count) begin
        count_d = i_wdata[WIDTH-1:0];
    end else if (cnt_tick) begin
        count_d = at_period ? {WIDTH{1'b0}} : count_q + 1'b1;
    end
end

// set wins over a clear in the same cycle
always @* begin
    flag_d = flag_q;
    if (match_evt || gate_evt) begin
        flag_d = 1'b1;
    end else if (clr_flag) begin
        flag_d = 1'b0;
    end
end

// read data stand one cycle, zero otherwise
always @* begin
    rdata_d = 16'h0000;
    if (i_rd) begin
        case (i_addr)
            `GPT16_ADDR_CONTROL: rdata_d = control_q;
            `GPT16_ADDR_PERIOD:  rdata_d = period_q;
            `GPT16_ADDR_COUNT:   rdata_d = count_q;
            `GPT16_ADDR_STATUS:  rdata_d = {15'h0, flag_q};
            default:             rdata_d = 16'h0000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// time base and input sampling

always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        half_q <= 1'b0;
    end else begin
        half_q <= ~half_q;
    end
end

// with ext_sync set the second stage feeds the counter logic; with it clear the raw pin does
always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        ext_s1_q <= 1'b0;
        ext_s2_q <= 1'b0;
    end else begin
        ext_s1_q <= i_ext_count_input;
        ext_s2_q <= ext_s1_q;
    end
end

always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        ext_prev_q  <= 1'b0;
        gate_prev_q <= 1'b0;
    end else begin
        ext_prev_q  <= ext_level;
        gate_prev_q <= i_gate;
    end
end

////////////////////////////////////////////////////////////////////////////////
// prescaler and counter

always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        psc_q   <= 8'h00;
        count_q <= {WIDTH{1'b0}};
    end else begin
        psc_q   <= psc_d;
        count_q <= count_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// software registers

always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        control_q <= `GPT16_CONTROL_RST;
        period_q  <= `GPT16_PERIOD_RST;
    end else begin
        if (wr_control) begin
            control_q <= i_wdata & `GPT16_CONTROL_MASK;
        end
        if (wr_period) begin
            period_q <= i_wdata[WIDTH-1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt flag and outputs

always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        flag_q        <= 1'b0;
        o_rdata       <= 16'h0000;
        o_irq_flag    <= 1'b0;
        o_match_pulse <= 1'b0;
    end else begin
        flag_q        <= flag_d;
        o_rdata       <= rdata_d;
        o_irq_flag    <= flag_q | match_evt | gate_evt;
        o_match_pulse <= match_evt;
    end
end

endmodule
`default_nettype wire

// file: src/gpt16_regs.vh
// register map, field positions and constants of the gated prescaled timer
`ifndef GPT16_REGS_VH
`define GPT16_REGS_VH

// register addresses
`define GPT16_ADDR_CONTROL   4'h0
`define GPT16_ADDR_PERIOD    4'h1
`define GPT16_ADDR_COUNT     4'h2
`define GPT16_ADDR_STATUS    4'h3

// timer_control fields
`define GPT16_BIT_TIMER_ON   15
`define GPT16_BIT_IDLE_STOP  13
`define GPT16_BIT_GATE_EN    6
`define GPT16_BIT_PSC_HI     5
`define GPT16_BIT_PSC_LO     4
`define GPT16_BIT_EXT_SYNC   2
`define GPT16_BIT_CLK_SRC    1
`define GPT16_CONTROL_MASK   16'ha076

// status fields
`define GPT16_BIT_FLAG       0

// reset values
`define GPT16_CONTROL_RST    16'h0000
`define GPT16_PERIOD_RST     16'hffff

// prescale terminal counts (ratio minus one)
`define GPT16_PSC_DIV1       8'h00
`define GPT16_PSC_DIV8       8'h07
`define GPT16_PSC_DIV64      8'h3f
`define GPT16_PSC_DIV256     8'hff

`endif

// file: bench/gpt16_assertions.sv
// port checker of the timer
`default_nettype none
`include "gpt16_regs.vh"
module gpt16_assertions (
    input wire logic        i_ref_clk, i_reset_n, i_wr, i_rd, i_idle, i_sleep,
    input wire logic        i_ext_count_input, i_gate, o_irq_flag, o_match_pulse,
    input wire logic [3:0]  i_addr,
    input wire logic [15:0] i_wdata, o_rdata
);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    wire clr_w = i_wr && i_addr == 4'h3 && i_wdata[0];
    property p_idle; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_mask; $past(i_rd && i_addr == 4'h0) |-> (o_rdata & ~`GPT16_CONTROL_MASK) == 16'h0000; endproperty
    a_mask: assert property (p_mask) else $error("control bits");
    property p_unmap; $past(i_rd && i_addr > 4'h3) |-> o_rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_one; o_match_pulse |=> !o_match_pulse; endproperty
    a_one: assert property (p_one) else $error("pulse width");
    property p_flag; o_match_pulse && !clr_w |=> o_irq_flag; endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    property p_stick; o_irq_flag && !clr_w && !$past(clr_w) |=> o_irq_flag; endproperty
    a_stick: assert property (p_stick) else $error("flag lost");
    property p_ctl; i_wr && i_addr == 4'h0 ##1 i_rd && i_addr == 4'h0
        |=> o_rdata == ($past(i_wdata, 2) & `GPT16_CONTROL_MASK); endproperty
    a_ctl: assert property (p_ctl) else $error("control readback");
    property p_per; i_wr && i_addr == 4'h1 ##1 i_rd && i_addr == 4'h1 |=> o_rdata == $past(i_wdata, 2); endproperty
    a_per: assert property (p_per) else $error("period readback");
    c_match: cover property (o_match_pulse);
    c_gate: cover property ($rose(o_irq_flag) && !$past(o_match_pulse));
    c_clr: cover property (clr_w && o_irq_flag);
endmodule
bind gpt16_timer gpt16_assertions gpt16_assertions_inst (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_wr(i_wr), .i_rd(i_rd), .i_idle(i_idle), .i_sleep(i_sleep),
    .i_ext_count_input(i_ext_count_input), .i_gate(i_gate), .o_irq_flag(o_irq_flag),
    .o_match_pulse(o_match_pulse), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata)
);
`default_nettype wire

// file: bench/gpt16_partner.sv
// external count source, still outside runs
`default_nettype none
module gpt16_partner (
    input  wire logic i_ref_clk,
    input  wire logic i_run,
    output logic      o_ext_count_input
);
    timeunit 1ns; timeprecision 1ns;
    logic [1:0] ph_q = 2'h0;
    always @(posedge i_ref_clk) ph_q <= i_run ? ph_q + 2'h1 : 2'h0;
    assign o_ext_count_input = ph_q[1]; // one rising edge each four cycles
endmodule
`default_nettype wire

// file: bench/tb_gpt16_timer.sv
// register-level testbench of the timer
`default_nettype none
module tb_gpt16_timer;
    timeunit 1ns; timeprecision 1ns;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, idle = 0, sleep = 0, gate = 0, run = 0;
    logic [3:0]  addr = 0;
    logic [15:0] wdata = 0;
    wire  [15:0] rdata;
    wire         ext, irq, pulse;
    int fail_count = 0, compares = 0, ratio[4] = '{1, 8, 64, 256};
    gpt16_timer gpt16_timer_inst (.i_ref_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_idle(idle), .i_sleep(sleep),
        .i_ext_count_input(ext), .i_gate(gate), .o_irq_flag(irq), .o_match_pulse(pulse));
    gpt16_partner gpt16_partner_inst (.i_ref_clk(clk), .i_run(run), .o_ext_count_input(ext));
    initial forever #20 clk = ~clk;
    task chk(input logic ok);
        compares++;
        if (!ok) begin
            fail_count++;
            $display("mismatch at %0t: wrong value", $time);
        end
    endtask
    task results;
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wr_t(input logic [3:0] a, input logic [15:0] d);
        // a write just ended: let its edge pass before raising the strobe again
        if (wr === 1'b1) @(posedge clk);
        addr <= a; wdata <= d; wr <= 1; @(posedge clk); wr <= 0;
    endtask
    task rd_t(input logic [3:0] a, input logic [15:0] e);
        addr <= a; rd <= 1; @(posedge clk); rd <= 0; @(negedge clk); chk(rdata === e); @(posedge clk);
    endtask
    // cycles between two match pulses, 1100 when none
    task gap(input logic [15:0] c, input int e);
        int n;
        wr_t(4'h0, c);
        repeat (2) begin
            n = 0;
            do begin @(negedge clk); n++; end while (pulse !== 1'b1 && n < 1100);
        end
        chk(n == e);
        @(posedge clk);
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        results;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1; @(posedge clk);
        rd_t(4'h0, 16'h0000);
        rd_t(4'h1, 16'hffff);
        wr_t(4'h0, 16'hffff); rd_t(4'h0, 16'ha076);
        wr_t(4'h0, 16'h0000); rd_t(4'h5, 16'h0000);
        wr_t(4'h2, 16'hfffe); rd_t(4'h2, 16'hfffe);
        wr_t(4'h2, 16'h0000); wr_t(4'h1, 16'h0001); rd_t(4'h1, 16'h0001);
        gap(16'h0000, 1100);
        for (int i = 0; i < 4; i++) gap(16'h8000 | 16'(i << 4), 4 * ratio[i]);
        chk(irq === 1'b1);
        rd_t(4'h3, 16'h0001);
        wr_t(4'h0, 16'h0000); wr_t(4'h3, 16'h0001); repeat (3) @(negedge clk); chk(irq === 1'b0);
        @(posedge clk); rd_t(4'h3, 16'h0000); idle <= 1;
        gap(16'ha000, 1100);
        gap(16'h8000, 4);
        sleep <= 1; gap(16'h8000, 1100);
        run <= 1; gap(16'h8002, 8);
        gap(16'h8006, 8);
        gap(16'h8042, 8);
        idle <= 0; sleep <= 0; run <= 0; gap(16'h8040, 1100);
        gate <= 1; gap(16'h8040, 4);
        wr_t(4'h0, 16'h0000); wr_t(4'h3, 16'h0001); wr_t(4'h1, 16'hffff); wr_t(4'h0, 16'h8040);
        repeat (20) @(posedge clk); chk(irq === 1'b0);
        gate <= 0; repeat (6) @(negedge clk); chk(irq === 1'b1);
        @(posedge clk); rst_n <= 0; repeat (3) @(negedge clk); chk(irq === 1'b0);
        @(posedge clk); rst_n <= 1; @(posedge clk);
        rd_t(4'h0, 16'h0000); rd_t(4'h1, 16'hffff); rd_t(4'h2, 16'h0000);
        results;
    end
endmodule
`default_nettype wire
